// ---- rtl/cascade_pkg.sv ----
`default_nettype none
package cascade_pkg;
  // Data path and chain shape
  localparam int WORD_WIDTH = 9;
  localparam int STAGES = 2;
  localparam int STAGE_DEPTH = 16384;
  // Clock and fixed latency
  localparam int CLK_PERIOD_NS = 10;
  localparam int FIXED_LATENCY_NS = 60;
  localparam int FIXED_LATENCY_CYC = (FIXED_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Tick counts for words and vacancies moving along the chain
  localparam int XFER_TICKS_PER_STAGE = 4;
  localparam int LAST_RD_TICKS_FALL = 2;
  localparam int LAST_RD_TICKS_STD = 1;
  localparam int FIRST_WR_TICKS_VACANCY = 3;
  // Other-end defaults
  localparam int WR_DIV = 2;
  localparam int RD_DIV = 3;
  localparam int MASTER_RESET_CYC = 4;
  localparam logic MODE_RESET = 1'b1;
  localparam logic LEGACY_STRAP = 1'b0;
endpackage
`default_nettype wire

// ---- rtl/cascade_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface cascade_if #(
  parameter int WIDTH = cascade_pkg::WORD_WIDTH
);
  // Clock enables standing in for the write, read and transfer clocks
  logic wr_clk_en;
  logic rd_clk_en;
  logic xfer_clk_en;
  // Setup
  logic master_reset_n;
  logic fall_through_mode;
  logic legacy_clock_select_pin;
  logic rewind;
  // Write side of the first stage
  logic wr_en;
  logic [WIDTH-1:0] wr_data;
  logic input_ready_n;
  // Read side of the last stage
  logic rd_en;
  logic [WIDTH-1:0] rd_data;
  logic output_ready_n;

  modport device (
    input wr_clk_en, rd_clk_en, xfer_clk_en, master_reset_n, fall_through_mode,
    input legacy_clock_select_pin, rewind, wr_en, wr_data, rd_en,
    output input_ready_n, rd_data, output_ready_n
  );
  modport ctrl (
    output wr_clk_en, rd_clk_en, xfer_clk_en, master_reset_n, fall_through_mode,
    output legacy_clock_select_pin, rewind, wr_en, wr_data, rd_en,
    input input_ready_n, rd_data, output_ready_n
  );
endinterface
`default_nettype wire

// ---- rtl/fifo_cascade.sv ----
// Function
// - Controller selects fall-through mode during master reset
// - Stage outputs feed next stage; depths add
// - Word at outputs drops ready; writes next
// - Read clock keeps running for ripple down
// - Last ready after (N-1)*4 transfer plus read
// - Chain delay only for first word
// - Freed slot drops input ready; bubbles up
// - Transfer clock follows faster of write, read
// - First word latency 60ns plus read periods
// - Retransmit latency 60ns plus read periods
// - Legacy clock select strapped, never toggles
// - Write and read clocks free-running, neither halts
`timescale 1ns/100ps
`default_nettype none
module fifo_cascade #(
  parameter int WIDTH = cascade_pkg::WORD_WIDTH,
  parameter int STAGES = cascade_pkg::STAGES,
  parameter int DEPTH = cascade_pkg::STAGE_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Chain link
  cascade_if.device link,
  // Status of every stage output
  output logic [STAGES-1:0] stage_out_ready_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int LW = $clog2(cascade_pkg::FIXED_LATENCY_CYC + 1);

  logic or_n_q [STAGES];
  logic ir_n_q [STAGES];
  logic [WIDTH-1:0] dout_q [STAGES];
  logic mode_q;

  // Mode caught while master reset is held
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= cascade_pkg::MODE_RESET;
    end else if (!link.master_reset_n) begin
      mode_q <= link.fall_through_mode;
    end
  end

  for (genvar k = 0; k < STAGES; k++) begin : g_stage
    localparam bit LAST = (k == STAGES - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] din;
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [2:0] lat_q;
    logic [2:0] lat_target;
    logic [LW-1:0] ns_q;
    logic [2:0] vac_q;
    logic push;
    logic pop;
    logic fill;
    logic rt;
    logic waiting;
    logic lat_tick;
    logic lat_done;
    logic vac_wait;
    logic vac_tick;
    logic vac_done;

    // Writes into this stage
    if (k == 0) begin : g_head
      assign din = link.wr_data;
      assign push = link.wr_en & link.wr_clk_en & ~ir_n_q[k];
      assign vac_tick = link.wr_clk_en;
      assign vac_done = vac_tick & (vac_q == 3'(cascade_pkg::FIRST_WR_TICKS_VACANCY - 1));
    end else begin : g_body
      // Previous ready flag is this stage's write strobe
      assign din = dout_q[k-1];
      assign push = link.xfer_clk_en & ~or_n_q[k-1] & ~ir_n_q[k];
      assign vac_tick = link.xfer_clk_en;
      assign vac_done = vac_tick & (vac_q == 3'(cascade_pkg::XFER_TICKS_PER_STAGE - 1));
    end

    // Reads out of this stage
    if (LAST) begin : g_tail
      assign pop = link.rd_en & link.rd_clk_en & ~or_n_q[k];
      assign rt = link.rewind;
      // Fixed wait then read ticks, independent of write and transfer clock rates
      assign lat_tick = (ns_q == LW'(cascade_pkg::FIXED_LATENCY_CYC)) & link.rd_clk_en;
      assign lat_target = mode_q ? 3'(cascade_pkg::LAST_RD_TICKS_FALL)
                                 : 3'(cascade_pkg::LAST_RD_TICKS_STD);
    end else begin : g_mid
      assign pop = link.xfer_clk_en & ~or_n_q[k] & ~ir_n_q[k+1];
      assign rt = 1'b0;
      assign lat_tick = link.xfer_clk_en;
      assign lat_target = 3'(cascade_pkg::XFER_TICKS_PER_STAGE);
    end

    // Output register waits only while it is empty and words are held
    assign waiting = or_n_q[k] & (cnt_q != '0);
    assign lat_done = waiting & lat_tick & (lat_q == lat_target - 3'd1);
    assign fill = (cnt_q != '0) & ~rt & (or_n_q[k] ? lat_done : pop);
    assign vac_wait = ir_n_q[k] & (cnt_q != CW'(DEPTH));

    // Occupancy of the stage memory
    always_comb begin
      if (rt) begin
        cnt_d = CW'(wptr_q) + CW'(push);
      end else begin
        cnt_d = cnt_q + CW'(push) - CW'(fill);
      end
    end

    // Storage
    always_ff @(posedge clock) begin
      if (push) begin
        mem[wptr_q] <= din;
      end
    end

    // Pointers and count
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        wptr_q <= '0;
        rptr_q <= '0;
        cnt_q <= '0;
      end else if (!link.master_reset_n) begin
        wptr_q <= '0;
        rptr_q <= '0;
        cnt_q <= '0;
      end else begin
        if (push) begin
          wptr_q <= wptr_q + 1'b1;
        end
        if (rt) begin
          rptr_q <= '0;
        end else if (fill) begin
          rptr_q <= rptr_q + 1'b1;
        end
        cnt_q <= cnt_d;
      end
    end

    // Fall-through output word and its ready flag
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        or_n_q[k] <= 1'b1;
        dout_q[k] <= '0;
      end else if (!link.master_reset_n) begin
        or_n_q[k] <= 1'b1;
        dout_q[k] <= '0;
      end else if (rt) begin
        or_n_q[k] <= 1'b1;
      end else if (fill) begin
        dout_q[k] <= mem[rptr_q];
        or_n_q[k] <= 1'b0;
      end else if (pop) begin
        or_n_q[k] <= 1'b1;
      end
    end

    // First-word delay counters
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        lat_q <= '0;
        ns_q <= '0;
      end else if (!waiting || rt || !link.master_reset_n) begin
        lat_q <= '0;
        ns_q <= '0;
      end else begin
        if (ns_q != LW'(cascade_pkg::FIXED_LATENCY_CYC)) begin
          ns_q <= ns_q + 1'b1;
        end
        if (lat_tick) begin
          lat_q <= lat_q + 3'd1;
        end
      end
    end

    // Input ready flag; full raises it at once, a vacancy lowers it late
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        ir_n_q[k] <= 1'b1;
        vac_q <= '0;
      end else if (!link.master_reset_n) begin
        ir_n_q[k] <= 1'b1;
        vac_q <= '0;
      end else if (cnt_d == CW'(DEPTH)) begin
        ir_n_q[k] <= 1'b1;
        vac_q <= '0;
      end else if (vac_wait && vac_done) begin
        ir_n_q[k] <= 1'b0;
        vac_q <= '0;
      end else if (vac_wait && vac_tick) begin
        vac_q <= vac_q + 3'd1;
      end else if (!vac_wait) begin
        vac_q <= '0;
      end
    end

    assign stage_out_ready_n[k] = or_n_q[k];
  end

  // Chain ends onto the link; timing rests on the enables plus the fixed clock-cycle wait of the last stage
  assign link.input_ready_n = ir_n_q[0];
  assign link.output_ready_n = or_n_q[STAGES-1];
  assign link.rd_data = dout_q[STAGES-1];

endmodule // fifo_cascade
`default_nettype wire

// ---- rtl/cascade_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module cascade_ctrl #(
  parameter int WIDTH = cascade_pkg::WORD_WIDTH,
  parameter int WR_DIV = cascade_pkg::WR_DIV,
  parameter int RD_DIV = cascade_pkg::RD_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Chain link
  cascade_if.ctrl link,
  // Writer side
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  // Reader side
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready,
  // Retransmit request, one-cycle pulse
  input wire logic rewind_req
);
  localparam bit XFER_IS_WR = (WR_DIV <= RD_DIV);
  localparam int MW = $clog2(cascade_pkg::MASTER_RESET_CYC + 1);

  logic [15:0] wdiv_q;
  logic [15:0] rdiv_q;
  logic wr_tick_q;
  logic rd_tick_q;
  logic xfer_tick_q;
  logic [MW-1:0] mrst_cnt_q;
  logic mrst_n_q;
  logic mode_q;
  logic strap_q;
  logic rewind_q;
  logic hold_full_q;
  logic hold_full_d;
  logic [WIDTH-1:0] hold_q;
  logic out_full_q;
  logic out_full_d;
  logic take_in;
  logic sent;
  logic got;

  // Free-running dividers; read clock enable never stops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdiv_q <= '0;
      rdiv_q <= '0;
      wr_tick_q <= 1'b0;
      rd_tick_q <= 1'b0;
      xfer_tick_q <= 1'b0;
    end else begin
      wdiv_q <= (wdiv_q == 16'(WR_DIV - 1)) ? '0 : wdiv_q + 16'h0001;
      rdiv_q <= (rdiv_q == 16'(RD_DIV - 1)) ? '0 : rdiv_q + 16'h0001;
      wr_tick_q <= (wdiv_q == 16'(WR_DIV - 1));
      rd_tick_q <= (rdiv_q == 16'(RD_DIV - 1));
      xfer_tick_q <= XFER_IS_WR ? (wdiv_q == 16'(WR_DIV - 1))
                                : (rdiv_q == 16'(RD_DIV - 1));
    end
  end

  // Master reset with mode and strap held steady
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mrst_cnt_q <= '0;
      mrst_n_q <= 1'b0;
      mode_q <= 1'b1;
      strap_q <= cascade_pkg::LEGACY_STRAP;
    end else if (mrst_cnt_q != MW'(cascade_pkg::MASTER_RESET_CYC)) begin
      mrst_cnt_q <= mrst_cnt_q + 1'b1;
    end else begin
      mrst_n_q <= 1'b1;
    end
  end

  assign sent = hold_full_q & wr_tick_q & ~link.input_ready_n;
  assign got = ~out_full_q & rd_tick_q & ~link.output_ready_n;
  // Take a word only on the user handshake itself, never before wr_ready shows
  assign take_in = wr_valid & wr_ready;
  assign hold_full_d = take_in | (hold_full_q & ~sent);
  assign out_full_d = got | (out_full_q & ~rd_ready);

  // Writer holding register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_full_q <= 1'b0;
      hold_q <= '0;
      wr_ready <= 1'b0;
    end else begin
      hold_full_q <= hold_full_d;
      wr_ready <= ~hold_full_d & mrst_n_q;
      if (take_in) begin
        hold_q <= wr_data;
      end
    end
  end

  // Reader output register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_full_q <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      out_full_q <= out_full_d;
      rd_valid <= out_full_d;
      if (got) begin
        rd_data <= link.rd_data;
      end
    end
  end

  // Retransmit pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rewind_q <= 1'b0;
    end else begin
      rewind_q <= rewind_req & mrst_n_q;
    end
  end

  assign link.wr_clk_en = wr_tick_q;
  assign link.rd_clk_en = rd_tick_q;
  assign link.xfer_clk_en = xfer_tick_q;
  assign link.master_reset_n = mrst_n_q;
  assign link.fall_through_mode = mode_q;
  assign link.legacy_clock_select_pin = strap_q;
  assign link.rewind = rewind_q;
  assign link.wr_en = hold_full_q;
  assign link.wr_data = hold_q;
  assign link.rd_en = ~out_full_q;

endmodule // cascade_ctrl
`default_nettype wire

// ---- test/cascade_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module cascade_assertions #(
  parameter int WIDTH = cascade_pkg::WORD_WIDTH,
  parameter int STAGES = cascade_pkg::STAGES,
  parameter int DEPTH = cascade_pkg::STAGE_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link signals
  input wire logic wr_clk_en,
  input wire logic rd_clk_en,
  input wire logic xfer_clk_en,
  input wire logic master_reset_n,
  input wire logic fall_through_mode,
  input wire logic legacy_clock_select_pin,
  input wire logic rewind,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic input_ready_n,
  input wire logic rd_en,
  input wire logic [WIDTH-1:0] rd_data,
  input wire logic output_ready_n
);
  localparam int CAP = STAGES * (DEPTH + 1);
  int occ_q;
  logic rw_q;
  logic rd_take;
  // Word leaving the last stage
  assign rd_take = rd_en && rd_clk_en && !output_ready_n;
  // Chain occupancy, meaningless once a rewind replays words
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      occ_q <= 0;
      rw_q <= 1'b0;
    end else begin
      occ_q <= occ_q + int'(wr_en && wr_clk_en && !input_ready_n) - int'(rd_take);
      rw_q <= rw_q || rewind;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_mode_fall_through: assert property ($rose(master_reset_n) |-> fall_through_mode)
    else $error("mode not fall-through at reset end");
  a_strap_steady: assert property (master_reset_n |=> $stable(legacy_clock_select_pin))
    else $error("legacy strap changed after reset");
  a_read_tick_runs: assert property ((master_reset_n && rd_clk_en) |=>
    !rd_clk_en [*2] ##1 rd_clk_en) else $error("read tick stopped");
  a_xfer_on_fast: assert property (master_reset_n |-> xfer_clk_en == wr_clk_en)
    else $error("transfer tick not on write tick");
  a_write_stands: assert property ((wr_en && !(wr_clk_en && !input_ready_n)) |=>
    wr_en && $stable(wr_data)) else $error("write dropped before taken");
  a_word_stands: assert property ((!output_ready_n && !rd_take && !rewind) |=>
    !output_ready_n && $stable(rd_data)) else $error("output word lost");
  a_rewind_quiet: assert property (rewind |=> output_ready_n [*6])
    else $error("output early after rewind");
  a_rewind_back: assert property (rewind |-> ##[8:20] !output_ready_n)
    else $error("no word after rewind");
  a_full_refuses: assert property ((occ_q == CAP && !rw_q) |-> input_ready_n)
    else $error("input ready while full");
  a_empty_quiet: assert property ((occ_q == 0 && !rw_q) |-> output_ready_n)
    else $error("output ready while empty");
  a_vacancy_up: assert property ((occ_q == CAP && rd_take && !rw_q) |->
    ##[2:40] !input_ready_n) else $error("vacancy never reached input");
  // Main scenarios reached
  c_full: cover property (occ_q == CAP);
  c_rewind: cover property (rewind ##1 output_ready_n);
  c_read: cover property (rd_take);
endmodule // cascade_assertions
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int DEPTH = 4;
  localparam int CAP = cascade_pkg::STAGES * (DEPTH + 1) + 2;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr_valid = 1'b0;
  logic rd_ready = 1'b0;
  logic rewind_req = 1'b0;
  logic [8:0] wr_data = 9'h000;
  logic [8:0] rd_data;
  logic wr_ready;
  logic rd_valid;
  logic [cascade_pkg::STAGES-1:0] stage_n;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int acc = 0;
  int wt[$];
  int rt[$];
  logic [8:0] rq[$];
  cascade_if link ();
  fifo_cascade #(.DEPTH(DEPTH)) i_fifo_cascade (.clock, .rst, .link(link),
    .stage_out_ready_n(stage_n));
  cascade_ctrl i_cascade_ctrl (.clock, .rst, .link(link), .wr_valid, .wr_data, .wr_ready,
    .rd_valid, .rd_data, .rd_ready, .rewind_req);
  cascade_assertions #(.DEPTH(DEPTH)) i_cascade_assertions (.clock, .rst,
    .wr_clk_en(link.wr_clk_en), .rd_clk_en(link.rd_clk_en), .xfer_clk_en(link.xfer_clk_en),
    .master_reset_n(link.master_reset_n), .fall_through_mode(link.fall_through_mode),
    .legacy_clock_select_pin(link.legacy_clock_select_pin),
    .rewind(link.rewind), .wr_en(link.wr_en), .wr_data(link.wr_data),
    .input_ready_n(link.input_ready_n), .rd_en(link.rd_en), .rd_data(link.rd_data),
    .output_ready_n(link.output_ready_n));
  // Clock
  initial begin
    forever #5 clock = ~clock;
  end
  // Cycle count and user handshakes
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      acc <= acc + 1;
      wt.push_back(cyc);
    end
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      rt.push_back(cyc);
      rq.push_back(rd_data);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Offer one word, leave valid up once taken
  task automatic push(input logic [8:0] d);
    int n;
    n = acc;
    wr_data = d;
    wr_valid = 1'b1;
    while (acc == n) @(negedge clock);
  endtask
  task automatic wait_rd(input int n);
    int k;
    k = 0;
    while (rt.size() < n && k < 300) begin
      @(negedge clock);
      k++;
    end
    // Words missing when the limit runs out
    if (rt.size() < n) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, rt.size(), n);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    wt.delete();
    rt.delete();
    rq.delete();
    while (wr_ready !== 1'b1) @(negedge clock);
  endtask
  // Burst into an empty chain: first word ripples, the rest follow closely
  task automatic t_stream();
    rd_ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      push(9'h1a0 + 9'(i));
    end
    wr_valid = 1'b0;
    wait_rd(4);
    for (int i = 0; i < 4; i++) begin
      chk(32'(rq[i]), 32'(9'h1a0 + 9'(i)));
    end
    chk(32'(rt[0] - wt[0] inside {[14:40]}), 32'h1);
    chk(32'(rt[3] - rt[0] <= 30), 32'h1);
  endtask
  // Fill with the reader stalled until refused, then drain in order
  task automatic t_fill();
    int n;
    int m;
    int k;
    rd_ready = 1'b0;
    rt.delete();
    rq.delete();
    n = acc;
    k = 0;
    wr_valid = 1'b1;
    while (k < 60) begin
      wr_data = 9'h0f0 + 9'(acc - n);
      m = acc;
      @(negedge clock);
      k = (acc == m) ? k + 1 : 0;
    end
    wr_valid = 1'b0;
    chk(32'(acc - n), 32'(CAP));
    chk(32'(stage_n), 32'h0);
    rd_ready = 1'b1;
    wait_rd(CAP);
    for (int i = 0; i < CAP; i++) begin
      chk(32'(rq[i]), 32'(9'h0f0 + 9'(i)));
    end
  endtask
  // Fresh reset, two words read, then replay from the start
  task automatic t_rewind();
    do_reset();
    rd_ready = 1'b1;
    push(9'h055);
    push(9'h0aa);
    wr_valid = 1'b0;
    wait_rd(2);
    repeat (4) @(negedge clock);
    rewind_req = 1'b1;
    @(negedge clock);
    rewind_req = 1'b0;
    wait_rd(4);
    chk(32'(rq[2]), 32'h055);
    chk(32'(rq[3]), 32'h0aa);
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_stream();
    t_fill();
    t_rewind();
    print_verdict();
  end
  // Watchdog far beyond the expected run
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
